/* adc_seq_defines.vh */
`ifndef ADC_SEQ_DEFINES_VH
`define ADC_SEQ_DEFINES_VH
// Mode register 0 bit positions
`define MODE0_START_BIT 0
`define MODE0_SCAN_BIT 1
`define MODE0_REPEAT_BIT 2
// Mode register 1 channel select field
`define MODE1_CH_MSB 2
`define MODE1_CH_LSB 0
// Conversion time in converter clock states, and cycles per state
`define CONV_STATES 84
`define CYCLES_PER_STATE 1
`define CONV_CYCLES (`CONV_STATES * `CYCLES_PER_STATE)
`define CONV_CNT_W 7
// Reset values
`define CHANNEL_RESET 3'h0
`define RESULT_RESET 10'h000
// Repeat interrupt interval count
`define IRQ_EVERY_FOURTH 2'h3
`endif

/* adc_sequence_and_result_control.v */
// Contract
// - Repeat/scan bits pick single/repeat and fixed/sweep; single modes interrupt at completion.
// - Repeated sweep: each sweep end sets end flag, interrupts, busy stays one.
// - Clearing repeat bit: finish current conversion (fixed) or current sweep (sweep), then stop and clear busy.
// - Halt (light idle without keep, deep idle, stop) aborts conversion at once.
// - After halt, a repeat mode restarts its sequence from the first step.
// - After halt, a single mode stays stopped.
// - Each channel conversion takes 84 converter clock states.
// - Result pairs are read-only; software writes never change them.
// - Repeated fixed mode writes results to pairs 0,1,2,3 then wraps.
// - Other modes store result in pair given by channel modulo four.
// - Stored flag of a pair sets when a new result is written there.
// - Reading either register of a pair clears its stored flag.
// - Reading any result clears the conversion end flag.
// - Repeated fixed mode: interval bit picks irq every conversion or every fourth.
// - Channel field picks fixed input, or sweep from input 0 or 4.
// - Start by start bit or trigger falling edge when enabled; busy set; edges ignored.
// - Upper register holds result bits 9..2; lower holds bits 1..0 in 7..6.
`default_nettype none
`include "adc_seq_defines.vh"
module adc_sequence_and_result_control (
  input wire ref_clk,
  input wire rst,
  input wire modeReg0Write,
  input wire [7:0] modeReg0WrData,
  input wire modeReg1Write,
  input wire [7:0] modeReg1WrData,
  input wire repeatIrqInterval,
  input wire externalTriggerEnable,
  input wire externalTriggerPin,
  input wire lightIdle,
  input wire lightIdleKeepConverting,
  input wire deepIdle,
  input wire stopMode,
  input wire [9:0] comparatorResult,
  input wire [3:0] resultReadUpper,
  input wire [3:0] resultReadLower,
  output reg [2:0] analogInputSelect,
  output reg sampleStrobe,
  output reg conversionEndFlag,
  output reg converterBusyFlag,
  output reg conversionDoneIrq,
  output wire scanSelect,
  output wire repeatSelect,
  output wire [2:0] channelSelectField,
  output wire [31:0] resultUpperRegs,
  output wire [31:0] resultLowerRegs
);

  // ****************************************
  // Mode registers and trigger synchroniser
  // ****************************************
  reg scan_q;
  reg repeat_q;
  reg [2:0] chan_q;
  reg trigMeta_q;
  reg trigSync_q;
  reg trigPrev_q;
  wire startWrite;
  wire trigFall;
  wire halted;

  assign scanSelect = scan_q;
  assign repeatSelect = repeat_q;
  assign channelSelectField = chan_q;
  // Start bit is write-only; it reads back as zero
  assign startWrite = modeReg0Write & modeReg0WrData[`MODE0_START_BIT];
  assign trigFall = trigPrev_q & ~trigSync_q;
  assign halted = (lightIdle & ~lightIdleKeepConverting) | deepIdle | stopMode;

  // Pin idles high, so the synchroniser resets high to avoid a false edge
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      trigMeta_q <= 1'h1;
      trigSync_q <= 1'h1;
      trigPrev_q <= 1'h1;
    end
    else
    begin
      trigMeta_q <= externalTriggerPin;
      trigSync_q <= trigMeta_q;
      trigPrev_q <= trigSync_q;
    end
  end

  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      scan_q <= 1'h0;
      repeat_q <= 1'h0;
      chan_q <= `CHANNEL_RESET;
    end
    else
    begin
      if (modeReg0Write)
      begin
        scan_q <= modeReg0WrData[`MODE0_SCAN_BIT];
        repeat_q <= modeReg0WrData[`MODE0_REPEAT_BIT];
      end
      if (modeReg1Write)
        chan_q <= modeReg1WrData[`MODE1_CH_MSB:`MODE1_CH_LSB];
    end
  end

  // ****************************************
  // Conversion sequencer
  // ****************************************
  localparam IDLE = 2'b00;
  localparam CONVERT = 2'b01;
  localparam HALTED = 2'b10;

  reg [1:0] state_q;
  reg [`CONV_CNT_W-1:0] cnt_q;
  reg [1:0] seqPtr_q;
  reg [1:0] irqCnt_q;
  reg runRepeat_q;
  reg runScan_q;
  wire convDone;
  wire lastStep;
  wire [1:0] pairSel;
  wire [1:0] sweepEnd;
  wire [`CONV_CNT_W-1:0] lastCount;
  wire startNow;
  wire startScan;
  wire startRepeat;
  wire resultWrite;
  localparam [31:0] LAST_COUNT_FULL = `CONV_CYCLES - 1;

  // First input of a run: the group base in sweep mode, else the field itself
  function [2:0] firstChannel;
    input scanMode;
    input [2:0] field;
    begin
      if (scanMode)
        firstChannel = {field[2], 2'h0};
      else
        firstChannel = field;
    end
  endfunction

  // A trigger run takes its mode from the registers, a start write from its own data
  assign startNow = startWrite | ((state_q == IDLE) & externalTriggerEnable & trigFall);
  assign startScan = startWrite ? modeReg0WrData[`MODE0_SCAN_BIT] : scan_q;
  assign startRepeat = startWrite ? modeReg0WrData[`MODE0_REPEAT_BIT] : repeat_q;
  assign lastCount = LAST_COUNT_FULL[`CONV_CNT_W-1:0];
  // A halt or a restart in the completing cycle discards the result
  assign resultWrite = convDone & ~halted & ~startWrite;
  // Sweep covers input group base up to the selected input
  assign sweepEnd = chan_q[1:0];
  assign convDone = (state_q == CONVERT) && (cnt_q == lastCount);
  assign lastStep = ~runScan_q | (seqPtr_q == sweepEnd);
  assign pairSel = (runRepeat_q & ~runScan_q) ? seqPtr_q : analogInputSelect[1:0];

  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      state_q <= IDLE;
      cnt_q <= {`CONV_CNT_W{1'b0}};
      seqPtr_q <= 2'h0;
      irqCnt_q <= 2'h0;
      runRepeat_q <= 1'b0;
      runScan_q <= 1'b0;
      analogInputSelect <= 3'h0;
      sampleStrobe <= 1'b0;
      converterBusyFlag <= 1'b0;
      conversionDoneIrq <= 1'b0;
    end
    else
    begin
      sampleStrobe <= 1'b0;
      conversionDoneIrq <= 1'b0;
      case (state_q)
        IDLE, CONVERT:
        begin
          if (halted)
          begin
            // Abort at once; only a repeat run resumes after the halt
            converterBusyFlag <= 1'b0;
            cnt_q <= {`CONV_CNT_W{1'b0}};
            if (converterBusyFlag & runRepeat_q & repeat_q)
              state_q <= HALTED;
            else
              state_q <= IDLE;
          end
          else if (startNow)
          begin
            // Start bit restarts even mid-conversion; trigger only when idle
            state_q <= CONVERT;
            converterBusyFlag <= 1'b1;
            cnt_q <= {`CONV_CNT_W{1'b0}};
            seqPtr_q <= 2'h0;
            irqCnt_q <= 2'h0;
            runRepeat_q <= startRepeat;
            runScan_q <= startScan;
            analogInputSelect <= firstChannel(startScan, chan_q);
            sampleStrobe <= 1'b1;
          end
          else if (convDone)
          begin
            cnt_q <= {`CONV_CNT_W{1'b0}};
            seqPtr_q <= lastStep & runScan_q ? 2'h0 : seqPtr_q + 2'h1;
            if (runScan_q)
              analogInputSelect <= lastStep ? {chan_q[2], 2'b00}
                : analogInputSelect + 3'h1;
            if (~repeat_q & lastStep)
            begin
              // Single run done, or repeat cancelled: stop after this one
              state_q <= IDLE;
              converterBusyFlag <= 1'b0;
              conversionDoneIrq <= 1'b1;
            end
            else if (~repeat_q)
              sampleStrobe <= 1'b1;
            else
            begin
              sampleStrobe <= 1'b1;
              if (runScan_q)
                conversionDoneIrq <= lastStep;
              else
              begin
                irqCnt_q <= irqCnt_q + 2'h1;
                conversionDoneIrq <= ~repeatIrqInterval
                  | (irqCnt_q == `IRQ_EVERY_FOURTH);
              end
            end
          end
          else if (state_q == CONVERT)
            cnt_q <= cnt_q + {{(`CONV_CNT_W-1){1'b0}}, 1'b1};
        end
        HALTED:
        begin
          if (~halted)
          begin
            state_q <= CONVERT;
            converterBusyFlag <= 1'b1;
            seqPtr_q <= 2'h0;
            irqCnt_q <= 2'h0;
            analogInputSelect <= firstChannel(runScan_q, chan_q);
            sampleStrobe <= 1'b1;
          end
        end
        default:
          state_q <= IDLE;
      endcase
    end
  end

  // ****************************************
  // Result pairs, stored flags, end flag
  // ****************************************
  wire anyRead;
  wire endSet;

  assign anyRead = |(resultReadUpper | resultReadLower);
  // End flag sets at every completion the sequencer reports
  assign endSet = resultWrite & (lastStep | repeat_q & ~runScan_q);

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1)
    begin : pairs
      reg [9:0] result_q;
      reg stored_q;
      wire wr;
      assign wr = resultWrite & (pairSel == g);
      // No software write path exists into the result pairs
      always @(posedge ref_clk)
      begin
        if (rst)
        begin
          result_q <= `RESULT_RESET;
          stored_q <= 1'h0;
        end
        else
        begin
          if (wr)
            result_q <= comparatorResult;
          if (wr)
            stored_q <= 1'h1;
          else if (resultReadUpper[g] | resultReadLower[g])
            stored_q <= 1'h0;
        end
      end
      assign resultUpperRegs[8*g+7:8*g] = result_q[9:2];
      assign resultLowerRegs[8*g+7:8*g] = {result_q[1:0], 5'h00, stored_q};
    end
  endgenerate

  // ****************************************
  // Conversion end flag
  // ****************************************

  always @(posedge ref_clk)
  begin
    if (rst)
      conversionEndFlag <= 1'b0;
    else if (endSet)
      conversionEndFlag <= 1'b1;
    else if (anyRead)
      conversionEndFlag <= 1'b0;
  end

endmodule
`default_nettype wire

/* adc_seq_monitor.sv */
`default_nettype none
module adc_seq_checker (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic modeReg0Write,
  input wire logic [7:0] modeReg0WrData,
  input wire logic deepIdle,
  input wire logic lightIdle,
  input wire logic lightIdleKeepConverting,
  input wire logic stopMode,
  input wire logic [3:0] resultReadLower,
  input wire logic sampleStrobe,
  input wire logic conversionEndFlag,
  input wire logic converterBusyFlag,
  input wire logic conversionDoneIrq,
  input wire logic scanSelect,
  input wire logic [2:0] channelSelectField,
  input wire logic [2:0] analogInputSelect,
  input wire logic [31:0] resultUpperRegs,
  input wire logic [31:0] resultLowerRegs
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  // ****
  // Checks
  // ****
  chk_start_sets_busy: assert property (
    modeReg0Write && modeReg0WrData[0] && !deepIdle && !stopMode
    && !(lightIdle && !lightIdleKeepConverting)
    |=> converterBusyFlag && sampleStrobe) else $error("start did not set busy");
  chk_conv_time: assert property (
    conversionDoneIrq |-> $past(sampleStrobe, 84)) else $error("conversion length wrong");
  chk_irq_end_flag: assert property (
    conversionDoneIrq |-> conversionEndFlag) else $error("irq without end flag");
  chk_halt_aborts: assert property (
    deepIdle || stopMode |=> !converterBusyFlag && !conversionDoneIrq) else $error("halt ignored");
  chk_read_clears: assert property (
    resultReadLower[0] && !converterBusyFlag |=> !resultLowerRegs[0]) else $error("flag kept");
  chk_results_only_at_end: assert property (
    !$stable(resultUpperRegs) |-> $past(converterBusyFlag)) else $error("result changed");
  chk_stored_on_end: assert property (
    $rose(resultLowerRegs[0]) |-> $past(converterBusyFlag)) else $error("stored flag set early");
  chk_fixed_channel: assert property (
    sampleStrobe && !scanSelect |-> analogInputSelect == channelSelectField)
    else $error("wrong fixed channel");
  cover property (conversionDoneIrq && converterBusyFlag);
  cover property (sampleStrobe && scanSelect);
  cover property (deepIdle && converterBusyFlag);
endmodule
bind adc_sequence_and_result_control adc_seq_checker u_adc_seq_checker (.*);
`default_nettype wire

/* analog_input_model.sv */
`default_nettype none
module analog_input_model (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [2:0] analogInputSelect,
  input wire logic sampleStrobe,
  output logic [9:0] comparatorResult
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [6:0] sampleCount_q;
  // ****
  // Channel in top bits so each pair can be traced; low bits vary per sample
  // ****
  assign comparatorResult = {analogInputSelect, sampleCount_q};
  always @(posedge ref_clk)
    if (rst)
      sampleCount_q <= 7'h00;
    else if (sampleStrobe)
      sampleCount_q <= sampleCount_q + 7'h05;
endmodule
`default_nettype wire

/* adc_sequence_and_result_control_tb.sv */
`default_nettype none
module adc_sequence_and_result_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'h0, rst = 1'h1, modeReg0Write = 1'h0, modeReg1Write = 1'h0;
  logic repeatIrqInterval = 1'h0, externalTriggerEnable = 1'h0, externalTriggerPin = 1'h1;
  logic lightIdle = 1'h0, lightIdleKeepConverting = 1'h0, deepIdle = 1'h0, stopMode = 1'h0;
  logic [7:0] modeReg0WrData = 8'h00, modeReg1WrData = 8'h00;
  logic [3:0] resultReadUpper = 4'h0, resultReadLower = 4'h0;
  wire [9:0] comparatorResult;
  wire [2:0] analogInputSelect, channelSelectField;
  wire sampleStrobe, conversionEndFlag, converterBusyFlag, conversionDoneIrq;
  wire scanSelect, repeatSelect;
  wire [31:0] resultUpperRegs, resultLowerRegs;
  int n_mismatch = 0, comparisons = 0, n;
  adc_sequence_and_result_control u_adc_sequence_and_result_control (.*);
  analog_input_model u_analog_input_model (.*);
  initial
    forever #12.5 ref_clk = ~ref_clk;
  // ****
  // Helpers
  // ****
  task give_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task check(input bit ok, input string msg);
    comparisons++;
    if (!ok)
    begin
      n_mismatch++;
      $display("Error at %0t: %s", $time, msg);
    end
  endtask
  task wr(input bit toReg1, input logic [7:0] d);
    @(posedge ref_clk);
    modeReg0WrData <= d;
    modeReg1WrData <= d;
    modeReg0Write <= !toReg1;
    modeReg1Write <= toReg1;
    @(posedge ref_clk);
    modeReg0Write <= 1'h0;
    modeReg1Write <= 1'h0;
  endtask
  // Kind 0 waits for the irq, 2 for busy low, 3 for busy high
  task waitFor(input int kind, input int lim);
    for (n = 1; n <= lim; n++)
    begin
      @(posedge ref_clk);
      #1;
      if (kind == 0 ? conversionDoneIrq === 1'h1 : converterBusyFlag === kind[0])
        return;
    end
    n_mismatch++;
    $display("Error at %0t: wait ran out", $time);
    give_verdict;
  endtask
  // ****
  // Scenarios
  // ****
  task singleFixed;
    lightIdle <= 1'h1;
    lightIdleKeepConverting <= 1'h1;
    wr(1, 8'h03);
    wr(0, 8'h01);
    waitFor(0, 200);
    check(n == 84, "conversion time");
    check(converterBusyFlag === 1'h0 && conversionEndFlag === 1'h1, "end flags");
    check(channelSelectField === 3'h3, "channel field");
    check(resultUpperRegs[31:29] === 3'h3 && resultLowerRegs[24] === 1'h1, "pair 3");
    @(posedge ref_clk);
    resultReadUpper <= 4'h8;
    @(posedge ref_clk);
    resultReadUpper <= 4'h0;
    #1;
    check(resultLowerRegs[24] === 1'h0 && conversionEndFlag === 1'h0, "read clear");
    @(posedge ref_clk);
    lightIdle <= 1'h0;
  endtask
  task scanSingle;
    wr(1, 8'h06);
    wr(0, 8'h03);
    waitFor(0, 300);
    check(n == 252 && converterBusyFlag === 1'h0, "sweep end");
    check(resultUpperRegs[7:5] === 3'h4 && resultUpperRegs[23:21] === 3'h6, "sweep pairs");
    check(scanSelect === 1'h1, "scan readback");
    @(posedge ref_clk);
    resultReadLower <= 4'h1;
    @(posedge ref_clk);
    resultReadLower <= 4'h0;
    #1;
    check(resultLowerRegs[0] === 1'h0 && resultLowerRegs[16] === 1'h1, "lower read");
    @(posedge ref_clk);
  endtask
  task repeatFixed;
    repeatIrqInterval <= 1'h1;
    wr(1, 8'h02);
    wr(0, 8'h05);
    waitFor(0, 400);
    check(n == 336 && converterBusyFlag === 1'h1 && repeatSelect === 1'h1, "fourth irq");
    check(resultUpperRegs[7:5] === 3'h2 && resultUpperRegs[31:29] === 3'h2, "rotation");
    wr(0, 8'h00);
    waitFor(2, 100);
    check(n > 70, "stop after conversion");
    @(posedge ref_clk);
    repeatIrqInterval <= 1'h0;
  endtask
  task haltRun;
    wr(1, 8'h00);
    wr(0, 8'h07);
    waitFor(0, 100);
    check(n == 84 && converterBusyFlag === 1'h1, "sweep repeat");
    repeat (20) @(posedge ref_clk);
    deepIdle <= 1'h1;
    repeat (10) @(posedge ref_clk);
    check(converterBusyFlag === 1'h0, "halt abort");
    deepIdle <= 1'h0;
    waitFor(0, 100);
    check(n >= 84 && n <= 90, "restart");
    wr(0, 8'h00);
    waitFor(2, 100);
    wr(0, 8'h01);
    stopMode <= 1'h1;
    repeat (5) @(posedge ref_clk);
    stopMode <= 1'h0;
    repeat (100) @(posedge ref_clk);
    check(converterBusyFlag === 1'h0, "single stays stopped");
  endtask
  task triggerRun;
    externalTriggerEnable <= 1'h1;
    externalTriggerPin <= 1'h0;
    waitFor(3, 6);
    @(posedge ref_clk);
    externalTriggerPin <= 1'h1;
    repeat (5) @(posedge ref_clk);
    externalTriggerPin <= 1'h0;
    waitFor(0, 90);
    check(n == 78, "trigger run length");
    repeat (5) @(posedge ref_clk);
    check(converterBusyFlag === 1'h0, "edge in run ignored");
  endtask
  initial
  begin
    repeat (6) @(posedge ref_clk);
    rst <= 1'h0;
    singleFixed;
    scanSingle;
    repeatFixed;
    haltRun;
    triggerRun;
    give_verdict;
  end
endmodule
`default_nettype wire
